// ### pkg/fstc_defines.svh
// register offsets, field values, reset values and timing constants for frame start control
// assumes a plain register port with word-indexed addresses
`ifndef FSTC_DEFINES_SVH
`define FSTC_DEFINES_SVH

`define FSTC_ADDR_W            4
`define FSTC_DATA_W            32
// register offsets
`define FSTC_REG_TRIG_MODE     4'h0
`define FSTC_REG_TRIG_SRC      4'h1
`define FSTC_REG_EXP_MODE      4'h2
`define FSTC_REG_EXP_TIME      4'h3
`define FSTC_REG_PER_EN        4'h4
`define FSTC_REG_PERIOD        4'h5
`define FSTC_REG_SW_TRIG       4'h6
`define FSTC_REG_WAIT_STAT     4'h7
`define FSTC_REG_ACQ_TRIG_MODE 4'h8
`define FSTC_REG_MIN_PERIOD    4'h9
// field values
`define FSTC_SRC_SOFTWARE      3'h0
`define FSTC_EXP_TIMED         1'h0
// reset values
`define FSTC_EXP_TIME_RST      32'h0000_03e8
`define FSTC_PERIOD_RST        32'h0000_4e20
`define FSTC_MIN_PERIOD_RST    32'h0000_0064
// timing: time base in ns and the clock period in ns
`define FSTC_TIME_BASE_NS      1000
`define FSTC_CLK_PERIOD_NS     5
`define FSTC_TICK_CYCLES       (`FSTC_TIME_BASE_NS / `FSTC_CLK_PERIOD_NS)

`endif

// ### pkg/fstc_pkg.sv
// types shared by the frame start control files
// assumes the defines header is compiled alongside
package fstc_pkg;
   typedef enum logic [1:0] {
      FSTC_IDLE,
      FSTC_EXPOSE,
      FSTC_READOUT
   } fstc_state_e;
   typedef logic [31:0] fstc_word_t;
endpackage

// ### src/fstc_frame_start_ctrl.sv
// frame start control: free-run pacing and software-triggered timed exposure
// assumes software at a plain register port; one clock mclk, synchronous reset
//
// Notes on behaviour
// - exposure lasts the exposure register count times one microsecond, a count of zero as one
// - free run: period enabled and trigger off paces frames at the period
// - period disabled: no internal frame pacing at all
// - software trigger starts exposure only while waiting for frame start
// - waiting status drops at exposure start, returns when ready again
// - triggers arriving while not waiting are discarded
// - writing 1 to trigger register issues one trigger, self-clears afterwards
// - wait status register reads 1 when ready, 0 when not
// - one frame per accepted trigger
// - period shorter than the minimum is stretched to the minimum
`timescale 1ns/100ps
`include "fstc_defines.svh"
module fstc_frame_start_ctrl #(
   parameter int          TICK_CYCLES = `FSTC_TICK_CYCLES,
   parameter int          READOUT_US  = 16
) (
   input  wire logic                     mclk,
   input  wire logic                     reset,
   input  wire logic [`FSTC_ADDR_W-1:0]  regAddr,
   input  wire logic [`FSTC_DATA_W-1:0]  regWrData,
   input  wire logic                     regWr,
   input  wire logic                     regRd,
   output logic      [`FSTC_DATA_W-1:0]  regRdData,
   output logic                          exposureActive,
   output logic                          frameStart,
   output logic                          frameTriggerWait
);
   localparam logic [31:0] READOUT_LEN = 32'(READOUT_US);
   localparam logic [31:0] TICK_LEN    = 32'(TICK_CYCLES);

   fstc_pkg::fstc_state_e state_r;
   logic                  tick;
   logic                  trigMode_r;
   logic [2:0]            trigSrc_r;
   logic                  expMode_r;
   logic                  acqTrigMode_r;
   fstc_pkg::fstc_word_t  expTime_r;
   logic                  perEn_r;
   fstc_pkg::fstc_word_t  period_r;
   fstc_pkg::fstc_word_t  minPeriod_r;
   logic                  swTrig_r;
   fstc_pkg::fstc_word_t  expCnt_r;
   fstc_pkg::fstc_word_t  expSub_r;
   fstc_pkg::fstc_word_t  perCnt_r;
   logic                  ready;
   logic                  swAccept;
   logic                  freeRun;
   logic                  perHit;
   logic                  start;
   fstc_pkg::fstc_word_t  perEff;

   // register write decode used by every config process
   function automatic logic wrHit(input logic [`FSTC_ADDR_W-1:0] a);
      return regWr && (regAddr == a);
   endfunction

   fstc_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .mclk  (mclk),
      .reset (reset),
      .tick  (tick)
   );

   // configuration registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         trigMode_r    <= 1'b0;
         trigSrc_r     <= `FSTC_SRC_SOFTWARE;
         expMode_r     <= `FSTC_EXP_TIMED;
         acqTrigMode_r <= 1'b0;
         expTime_r     <= `FSTC_EXP_TIME_RST;
         perEn_r       <= 1'b0;
         period_r      <= `FSTC_PERIOD_RST;
         minPeriod_r   <= `FSTC_MIN_PERIOD_RST;
      end else begin
         if (wrHit(`FSTC_REG_TRIG_MODE))
            trigMode_r <= regWrData[0];
         if (wrHit(`FSTC_REG_TRIG_SRC))
            trigSrc_r <= regWrData[2:0];
         if (wrHit(`FSTC_REG_EXP_MODE))
            expMode_r <= regWrData[0];
         if (wrHit(`FSTC_REG_ACQ_TRIG_MODE))
            acqTrigMode_r <= regWrData[0];
         if (wrHit(`FSTC_REG_EXP_TIME))
            expTime_r <= regWrData;
         if (wrHit(`FSTC_REG_PER_EN))
            perEn_r <= regWrData[0];
         if (wrHit(`FSTC_REG_PERIOD))
            period_r <= regWrData;
         if (wrHit(`FSTC_REG_MIN_PERIOD))
            minPeriod_r <= regWrData;
      end
   end

   // acceptance terms; a trigger while busy is simply dropped
   assign ready    = (state_r == fstc_pkg::FSTC_IDLE);
   assign swAccept = swTrig_r && ready && trigMode_r
                     && (trigSrc_r == `FSTC_SRC_SOFTWARE);
   assign freeRun  = perEn_r && !trigMode_r;
   assign perEff   = (period_r < minPeriod_r) ? minPeriod_r : period_r;
   assign perHit   = freeRun && tick && (perCnt_r + 32'h1 >= perEff);
   assign start    = swAccept || (freeRun && ready && perHit);

   // software trigger: write of 1 arms it, cleared once taken or discarded
   always_ff @(posedge mclk) begin
      if (reset)
         swTrig_r <= 1'b0;
      else if (wrHit(`FSTC_REG_SW_TRIG) && regWrData[0])
         swTrig_r <= 1'b1;
      else if (swTrig_r)
         swTrig_r <= 1'b0;
   end

   // frame period counter in microsecond ticks, restarts at each frame start
   always_ff @(posedge mclk) begin
      if (reset || !freeRun)
         perCnt_r <= '0;
      else if (perHit && ready)
         perCnt_r <= '0;
      else if (tick && !perHit)
         perCnt_r <= perCnt_r + 32'h1;
   end

   // exposure then readout; one frame per start
   // exposure counts its own clocks from the start edge, so its length does not
   // depend on where the shared microsecond tick happens to fall
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r  <= fstc_pkg::FSTC_IDLE;
         expCnt_r <= '0;
         expSub_r <= '0;
      end else begin
         case (state_r)
            fstc_pkg::FSTC_IDLE: begin
               expCnt_r <= '0;
               expSub_r <= '0;
               if (start)
                  state_r <= fstc_pkg::FSTC_EXPOSE;
            end
            fstc_pkg::FSTC_EXPOSE: begin
               if (expSub_r + 32'h1 >= TICK_LEN) begin
                  expSub_r <= '0;
                  if (expCnt_r + 32'h1 >= expTime_r) begin
                     state_r  <= fstc_pkg::FSTC_READOUT;
                     expCnt_r <= '0;
                  end else begin
                     expCnt_r <= expCnt_r + 32'h1;
                  end
               end else begin
                  expSub_r <= expSub_r + 32'h1;
               end
            end
            fstc_pkg::FSTC_READOUT: begin
               if (tick) begin
                  if (expCnt_r + 32'h1 >= READOUT_LEN) begin
                     state_r <= fstc_pkg::FSTC_IDLE;
                  end else begin
                     expCnt_r <= expCnt_r + 32'h1;
                  end
               end
            end
            default: state_r <= fstc_pkg::FSTC_IDLE;
         endcase
      end
   end

   // outputs registered; wait status low from the cycle after the start cycle onward
   always_ff @(posedge mclk) begin
      if (reset) begin
         frameStart       <= 1'b0;
         exposureActive   <= 1'b0;
         frameTriggerWait <= 1'b0;
      end else begin
         frameStart       <= start && ready;
         exposureActive   <= (state_r == fstc_pkg::FSTC_EXPOSE);
         frameTriggerWait <= ready && !start;
      end
   end

   // read port: data valid the cycle after the strobe only
   always_ff @(posedge mclk) begin
      if (reset || !regRd) begin
         regRdData <= '0;
      end else begin
         case (regAddr)
            `FSTC_REG_TRIG_MODE:     regRdData <= {31'h0, trigMode_r};
            `FSTC_REG_TRIG_SRC:      regRdData <= {29'h0, trigSrc_r};
            `FSTC_REG_EXP_MODE:      regRdData <= {31'h0, expMode_r};
            `FSTC_REG_ACQ_TRIG_MODE: regRdData <= {31'h0, acqTrigMode_r};
            `FSTC_REG_EXP_TIME:      regRdData <= expTime_r;
            `FSTC_REG_PER_EN:        regRdData <= {31'h0, perEn_r};
            `FSTC_REG_PERIOD:        regRdData <= period_r;
            `FSTC_REG_MIN_PERIOD:    regRdData <= minPeriod_r;
            `FSTC_REG_SW_TRIG:       regRdData <= {31'h0, swTrig_r};
            `FSTC_REG_WAIT_STAT:     regRdData <= {31'h0, frameTriggerWait};
            default:                 regRdData <= '0;
         endcase
      end
   end

   // exposure length check counts cycles of the exposure output
   fstc_pkg::fstc_word_t expCycles_r;
   always_ff @(posedge mclk) begin
      if (reset || !exposureActive)
         expCycles_r <= '0;
      else
         expCycles_r <= expCycles_r + 32'h1;
   end

   sequence s_accept;
      swAccept;
   endsequence
   sequence s_started;
      ##1 (state_r == fstc_pkg::FSTC_EXPOSE) ##1 !frameTriggerWait;
   endsequence

   property p_sw_start;
      @(posedge mclk) disable iff (reset) s_accept |-> s_started;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("accepted trigger did not start");

   // a trigger dropped while busy must not linger until the controller is idle
   property p_drop_busy;
      @(posedge mclk) disable iff (reset)
         (swTrig_r && !ready && !(regWr && regAddr == `FSTC_REG_SW_TRIG)) |=> !swAccept;
   endproperty
   a_drop_busy: assert property (p_drop_busy) else $error("busy trigger changed state");

   property p_self_clear;
      @(posedge mclk) disable iff (reset)
         (swTrig_r && !(regWr && regAddr == `FSTC_REG_SW_TRIG)) |=> !swTrig_r;
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("trigger register not cleared");

   property p_wait_low;
      @(posedge mclk) disable iff (reset)
         (state_r != fstc_pkg::FSTC_IDLE) |=> !frameTriggerWait;
   endproperty
   a_wait_low: assert property (p_wait_low) else $error("wait status high while busy");

   property p_wait_read;
      @(posedge mclk) disable iff (reset)
         (regRd && regAddr == `FSTC_REG_WAIT_STAT) |=> (regRdData[0] == $past(frameTriggerWait));
   endproperty
   a_wait_read: assert property (p_wait_read) else $error("wait status read wrong");

   property p_no_pace;
      @(posedge mclk) disable iff (reset)
         (!perEn_r && !swAccept) |=> !frameStart;
   endproperty
   a_no_pace: assert property (p_no_pace) else $error("frame started without source");

   // an exposure runs exactly its count of microseconds, a count of zero as one
   property p_exp_len;
      @(posedge mclk) disable iff (reset)
         $fell(exposureActive) |->
            (expCycles_r == (($past(expTime_r) == 32'h0) ? TICK_LEN
                                                          : $past(expTime_r) * TICK_LEN));
   endproperty
   a_exp_len: assert property (p_exp_len) else $error("exposure length wrong");

   property p_one_frame;
      @(posedge mclk) disable iff (reset)
         frameStart |=> !frameStart;
   endproperty
   a_one_frame: assert property (p_one_frame) else $error("two frame starts back to back");

   property p_free_run;
      @(posedge mclk) disable iff (reset)
         (freeRun && ready && perHit) |=> frameStart;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free-run period missed");

   property p_per_restart;
      @(posedge mclk) disable iff (reset)
         (perHit && ready) |=> (perCnt_r == 32'h0);
   endproperty
   a_per_restart: assert property (p_per_restart) else $error("period counter not restarted");

   // wait status comes back the cycle after the controller is idle again
   sequence s_idle_free;
      ready && !start;
   endsequence
   property p_wait_back;
      @(posedge mclk) disable iff (reset) s_idle_free |=> frameTriggerWait;
   endproperty
   a_wait_back: assert property (p_wait_back) else $error("wait status not restored");

   property p_wait_ready;
      @(posedge mclk) disable iff (reset)
         frameTriggerWait |-> ready;
   endproperty
   a_wait_ready: assert property (p_wait_ready) else $error("wait status high while busy");

   // internal pacing never runs faster than the minimum period allows
   property p_min_period;
      @(posedge mclk) disable iff (reset)
         perHit |-> (perCnt_r + 32'h1 >= minPeriod_r);
   endproperty
   a_min_period: assert property (p_min_period) else $error("frame period below minimum");
endmodule

// ### src/fstc_tick_gen.sv
// microsecond time base: one pulse every tickCycles clocks
// assumes a free-running clock with synchronous active-high reset
`timescale 1ns/100ps
`include "fstc_defines.svh"
module fstc_tick_gen #(
   parameter int TICK_CYCLES = `FSTC_TICK_CYCLES
) (
   input  wire logic mclk,
   input  wire logic reset,
   output logic      tick
);
   localparam int CW = $clog2(TICK_CYCLES);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
   logic [CW-1:0] cnt_r;

   // divider counts up from zero to TICK_CYCLES - 1, then pulses once per microsecond
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else if (cnt_r == LAST) begin
         cnt_r <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick  <= 1'b0;
      end
   end
endmodule

// ### test/frame_start_trigger_ctrl_bench.sv
// self-checking bench for frame start control: registers, software trigger, free run
// assumes the defines header on the include path and the design assertions built in
`timescale 1ns/100ps
`include "fstc_defines.svh"
`define TB_CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failCount++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module frame_start_trigger_ctrl_bench;
   localparam int T  = 4;  // shortened microsecond so a frame stays short
   localparam int RO = 2;
   logic                    mclk;
   logic                    reset;
   logic [`FSTC_ADDR_W-1:0] regAddr;
   logic [`FSTC_DATA_W-1:0] regWrData;
   logic                    regWr;
   logic                    regRd;
   logic [`FSTC_DATA_W-1:0] regRdData;
   logic                    exposureActive;
   logic                    frameStart;
   logic                    frameTriggerWait;
   logic [`FSTC_DATA_W-1:0] rd;
   int                      failCount = 0;
   int                      compares = 0;
   int                      cyc = 0;
   int                      startCount = 0;
   int                      expTotal = 0;
   int                      lastStart = 0;
   int                      lastGap = 0;

   fstc_frame_start_ctrl #(.TICK_CYCLES(T), .READOUT_US(RO)) i_dut (
      .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .exposureActive(exposureActive), .frameStart(frameStart),
      .frameTriggerWait(frameTriggerWait));

   // clock, 5 ns period
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // counts frames, exposure cycles and the spacing of frame starts
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (exposureActive === 1'b1) expTotal <= expTotal + 1;
      if (frameStart === 1'b1) begin
         startCount <= startCount + 1;
         lastGap    <= cyc - lastStart;
         lastStart  <= cyc;
      end
   end

   task automatic closeOut();
      $display("comparisons %0d mismatches %0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a; regWrData <= d; regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so sample it there
   task automatic rdReg(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      regAddr <= a; regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask

   // bounded wait for a start pulse; one extra edge lets the monitor catch up
   task automatic waitStart();
      for (int i = 0; i < 2000; i++) begin
         @(posedge mclk);
         #1;
         if (frameStart === 1'b1) begin
            @(posedge mclk);
            #1;
            return;
         end
      end
      failCount++;
      $display("wrong value frameStart expected 1 seen 0");
   endtask

   task automatic tReset();
      repeat (3) @(posedge mclk);
      #1 `TB_CHK("waitPin", 1'b1, frameTriggerWait)
      rdReg(`FSTC_REG_EXP_TIME, rd);   `TB_CHK("expRst", `FSTC_EXP_TIME_RST, rd)
      rdReg(`FSTC_REG_PERIOD, rd);     `TB_CHK("perRst", `FSTC_PERIOD_RST, rd)
      rdReg(`FSTC_REG_MIN_PERIOD, rd); `TB_CHK("minRst", `FSTC_MIN_PERIOD_RST, rd)
      rdReg(4'hf, rd);                 `TB_CHK("unmapped", 32'h0, rd)
   endtask

   // software setup in the host order, then an overtrigger inside the frame
   task automatic tSoftware();
      int s0, e0, i;
      wrReg(`FSTC_REG_ACQ_TRIG_MODE, 32'h0);
      wrReg(`FSTC_REG_PER_EN, 32'h0);
      wrReg(`FSTC_REG_TRIG_MODE, 32'h1);
      wrReg(`FSTC_REG_TRIG_SRC, {29'h0, `FSTC_SRC_SOFTWARE});
      wrReg(`FSTC_REG_EXP_MODE, {31'h0, `FSTC_EXP_TIMED});
      wrReg(`FSTC_REG_EXP_TIME, 32'h5);
      rdReg(`FSTC_REG_TRIG_MODE, rd); `TB_CHK("modeReg", 32'h1, rd)
      rdReg(`FSTC_REG_WAIT_STAT, rd); `TB_CHK("waitReg", 32'h1, rd)
      s0 = startCount; e0 = expTotal;
      wrReg(`FSTC_REG_SW_TRIG, 32'h1);
      wrReg(`FSTC_REG_SW_TRIG, 32'h1); // lands while busy
      #1 `TB_CHK("waitBusy", 1'b0, frameTriggerWait)
      rdReg(`FSTC_REG_WAIT_STAT, rd); `TB_CHK("waitRegBusy", 32'h0, rd)
      rdReg(`FSTC_REG_SW_TRIG, rd);   `TB_CHK("trigClear", 32'h0, rd)
      for (i = 0; i < 300 && frameTriggerWait !== 1'b1; i++) @(posedge mclk) #1;
      `TB_CHK("waitBack", 1'b1, frameTriggerWait)
      repeat (2) @(posedge mclk);
      `TB_CHK("oneFrame", s0 + 1, startCount)
      `TB_CHK("expLen", 5 * T, expTotal - e0)
      wrReg(`FSTC_REG_SW_TRIG, 32'h1);
      waitStart();
      `TB_CHK("secondFrame", s0 + 2, startCount)
      wrReg(`FSTC_REG_TRIG_SRC, 32'h1); // a non-software source ignores the register
      rdReg(`FSTC_REG_TRIG_SRC, rd);  `TB_CHK("srcReg", 32'h1, rd)
      // idle first, so only the source setting can hold this trigger back
      for (i = 0; i < 300 && frameTriggerWait !== 1'b1; i++) @(posedge mclk) #1;
      s0 = startCount;
      wrReg(`FSTC_REG_SW_TRIG, 32'h1);
      repeat (80) @(posedge mclk);
      `TB_CHK("otherSrc", s0, startCount)
      wrReg(`FSTC_REG_TRIG_SRC, {29'h0, `FSTC_SRC_SOFTWARE});
   endtask

   task automatic tNoPace();
      int s0;
      wrReg(`FSTC_REG_TRIG_MODE, 32'h0);
      wrReg(`FSTC_REG_PERIOD, 32'h3);
      s0 = startCount;
      repeat (300) @(posedge mclk);
      `TB_CHK("noPace", s0, startCount)
   endtask

   // free run, then a period below the minimum which must be stretched
   task automatic tFreeRun();
      int g1;
      wrReg(`FSTC_REG_EXP_TIME, 32'h2);
      wrReg(`FSTC_REG_MIN_PERIOD, 32'h14);
      wrReg(`FSTC_REG_PER_EN, 32'h1);
      wrReg(`FSTC_REG_PERIOD, 32'h1e);
      repeat (2) waitStart();
      g1 = lastGap;
      `TB_CHK("gap", 30 * T, g1)
      waitStart();
      `TB_CHK("gapSteady", g1, lastGap)
      wrReg(`FSTC_REG_PERIOD, 32'h3);
      repeat (3) waitStart();
      `TB_CHK("clamp", 20 * T, lastGap)
      wrReg(`FSTC_REG_PER_EN, 32'h0);
   endtask

   // watchdog, far beyond the few thousand cycles the tests need
   initial begin
      #200000;
      failCount++;
      closeOut();
   end

   // reset for three cycles, then the scenarios
   initial begin
      reset = 1'b1; regAddr = '0; regWrData = '0; regWr = 1'b0; regRd = 1'b0;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      tReset();
      tSoftware();
      tNoPace();
      tFreeRun();
      closeOut();
   end
endmodule
